// >>> include/embc_pkg.sv
// Package for the external memory bus cycle block: constants, types.
// Assumes a single 100 MHz clock; all control bits arrive as plain ports.
package embc_pkg;
  localparam int EMBC_CLK_MHZ = 100;
  localparam int EMBC_CLK_PERIOD_NS = 1000 / EMBC_CLK_MHZ;
  // Fetch strobe duty: high part of first state, in tenths of a state
  localparam logic [3:0] EMBC_DUTY35_PHASES = 4'h4;
  localparam logic [3:0] EMBC_DUTY50_PHASES = 4'h5;
  localparam logic [3:0] EMBC_PHASES_PER_STATE = 4'ha;
  localparam logic [2:0] EMBC_BOOT_EXT8 = 3'h0;
  localparam logic [2:0] EMBC_BOOT_EXT16 = 3'h1;
  localparam logic [1:0] EMBC_SHIFT8 = 2'h0;
  localparam logic [1:0] EMBC_SHIFT9 = 2'h1;
  localparam logic [1:0] EMBC_SHIFT10 = 2'h2;
  localparam logic [7:0] EMBC_SEL_IDLE = 8'hff;
  localparam logic [2:0] EMBC_LW_RESET = 3'h0;

  typedef enum logic [4:0] {
    EMBC_IDLE = 5'h01,
    EMBC_T1 = 5'h02,
    EMBC_LWAIT = 5'h04,
    EMBC_PWAIT = 5'h08,
    EMBC_TLAST = 5'h10
  } embc_state_t;

  // One access request from the CPU or the dma_unit
  typedef struct packed {
    logic valid;
    logic [27:0] addr;
    logic write;
    logic [1:0] size; // 0 byte, 1 word
    logic dma_single;
  } embc_req_t;

  // Configuration bits, grouped after their owning registers
  typedef struct packed {
    logic dram_space_enable;
    logic muxed_io_enable;
    logic fetch_strobe_duty;
    logic lane_strobe_select;
    logic [7:0] wait_ctrl_first;
    logic [7:0] wait_ctrl_second;
    logic [1:0] long_wait_a02;
    logic [1:0] long_wait_a6;
    logic row_col_mux_enable;
    logic [1:0] row_shift_select;
  } embc_cfg_t;

  // Pin bundle, all active low strobes except address, A0 and row_phase
  typedef struct packed {
    logic [7:0] select_n;
    logic fetch_n;
    logic upper_store_n;
    logic lower_store_n;
    logic a0_pin;
    logic [21:0] addr;
    logic row_phase;
  } embc_pins_t;
endpackage

// >>> hw/embc_strobe_duty.sv
// Fetch strobe duty generator: phase counter across one state.
// Assumes a sub-state phase enable; state boundary marked by i_state_start.
module embc_strobe_duty
  import embc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_state_start,
  input wire logic i_duty35,
  output logic o_high
);
  typedef struct packed {
    logic [3:0] phase;
    logic high;
  } embc_duty_t;
  embc_duty_t s_reg, s_next;

  always_comb begin
    s_next = s_reg;
    if (i_state_start) begin
      s_next.phase = 4'h1;
      s_next.high = 1'b1;
    end else if (s_reg.phase != 4'h0 && s_reg.phase < EMBC_PHASES_PER_STATE)
    begin
      s_next.phase = s_reg.phase + 4'h1;
    end
    // High part of T1 then low for the rest
    if (!i_state_start) begin
      s_next.high = (s_reg.phase < (i_duty35 ? EMBC_DUTY35_PHASES
                                             : EMBC_DUTY50_PHASES))
                    && s_reg.phase != 4'h0 && s_reg.high;
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
  assign o_high = s_reg.high;
endmodule

// >>> hw/embc_top.sv
// External memory bus cycle controller: area decode, state sequencing,
// lane strobes and DRAM row/column address multiplex.
// Assumes requests held stable until o_done; inputs synchronous to clock.
module embc_top (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_boot_mode_pins,
  input wire embc_pkg::embc_cfg_t i_cfg,
  input wire embc_pkg::embc_req_t i_req,
  input wire logic i_wait_n,
  output logic o_done,
  output logic o_busy,
  output logic o_dram_access,
  output logic [7:0] o_select_n,
  output logic o_fetch_n,
  output logic o_upper_store_n,
  output logic o_lower_store_n,
  output logic o_a0_pin,
  output logic [21:0] o_addr,
  output logic o_row_phase
);
  import embc_pkg::*;
  typedef struct packed {
    embc_state_t state;
    logic [2:0] lw_left;
    logic pin_wait;
    logic two_state;
    logic done;
    logic busy;
    logic dram;
    embc_pins_t pins;
  } embc_top_t;
  embc_top_t s_reg, s_next;

  logic [2:0] area;
  logic a27;
  logic external;
  logic long_area;
  logic wait_bit;
  logic use_pin;
  logic bus16;
  logic [2:0] lw_count;
  logic [21:0] row_addr;
  logic fetch_high;
  logic state_start;

  assign area = i_req.addr[26:24];
  assign a27 = i_req.addr[27];

  // Area decode into external space
  always_comb begin
    external = 1'b0;
    bus16 = a27;
    case (area)
      3'h0: begin
        external = (i_boot_mode_pins == EMBC_BOOT_EXT8) ||
                   (i_boot_mode_pins == EMBC_BOOT_EXT16);
        bus16 = (i_boot_mode_pins == EMBC_BOOT_EXT16);
      end
      3'h1: external = 1'b1; // DRAM is external too
      3'h2, 3'h3, 3'h4: external = 1'b1;
      3'h5: begin
        external = a27;
        bus16 = 1'b1;
      end
      3'h6: begin
        external = !i_cfg.muxed_io_enable || a27;
        bus16 = a27 || i_req.addr[14];
      end
      3'h7: begin
        external = !a27;
        bus16 = 1'b0;
      end
      default: external = 1'b0;
    endcase
  end

  assign long_area = (area == 3'h0) || (area == 3'h2) || (area == 3'h6);
  // Single-mode DMA reads the second register
  assign wait_bit = i_req.dma_single ? i_cfg.wait_ctrl_second[area]
                                     : i_cfg.wait_ctrl_first[area];
  // Writes other than single-mode DMA bypass the first register and always use pin waits
  assign use_pin = (i_req.write && !i_req.dma_single) ? 1'b1 : wait_bit;
  assign lw_count = {1'b0, (area == 3'h6) ? i_cfg.long_wait_a6
                                          : i_cfg.long_wait_a02} + 3'h1;

  // Row address by shift select
  always_comb begin
    row_addr = '0;
    case (i_cfg.row_shift_select)
      EMBC_SHIFT8: row_addr = {6'h00, i_req.addr[23:8]};
      EMBC_SHIFT9: row_addr = {7'h00, i_req.addr[23:9]};
      EMBC_SHIFT10: row_addr = {8'h00, i_req.addr[23:10]};
      default: row_addr = {6'h00, i_req.addr[23:8]}; // Reserved code
    endcase
  end

  assign state_start = (s_reg.state == EMBC_IDLE) && i_req.valid;

  embc_strobe_duty u_duty (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_state_start(state_start),
    .i_duty35(i_cfg.fetch_strobe_duty),
    .o_high(fetch_high)
  );

  always_comb begin
    s_next = s_reg;
    s_next.done = 1'b0;
    case (s_reg.state)
      EMBC_IDLE: begin
        s_next.pins.select_n = EMBC_SEL_IDLE;
        s_next.pins.fetch_n = 1'b1;
        s_next.pins.upper_store_n = 1'b1;
        s_next.pins.lower_store_n = 1'b1;
        s_next.pins.row_phase = 1'b0;
        s_next.busy = 1'b0;
        if (i_req.valid) begin
          s_next.busy = 1'b1;
          s_next.state = EMBC_T1;
          s_next.dram = (area == 3'h1) && i_cfg.dram_space_enable;
          s_next.pin_wait = use_pin;
          s_next.two_state = use_pin && !long_area;
          s_next.lw_left = long_area ? lw_count : EMBC_LW_RESET;
          if (external && !s_next.dram) begin
            s_next.pins.select_n[area] = 1'b0;
          end
          // Address pins; DRAM multiplex drives row first
          if (s_next.dram && i_cfg.row_col_mux_enable) begin
            s_next.pins.addr = row_addr;
            s_next.pins.row_phase = 1'b1;
          end else begin
            s_next.pins.addr = i_req.addr[21:0];
          end
          s_next.pins.a0_pin = i_req.addr[0];
          s_next.pins.fetch_n = i_req.write;
          if (i_req.write) begin
            // Without lane select, even byte address is the upper lane, odd the lower
            if (bus16 && i_cfg.lane_strobe_select) begin
              // Common store strobe plus lane strobes
              s_next.pins.lower_store_n = 1'b0;
              s_next.pins.upper_store_n =
                !(i_req.size != 2'h0 || i_req.addr[0]);
              s_next.pins.a0_pin = !(i_req.size != 2'h0 || !i_req.addr[0]);
            end else if (bus16) begin
              s_next.pins.upper_store_n =
                !(i_req.size != 2'h0 || !i_req.addr[0]);
              s_next.pins.lower_store_n =
                !(i_req.size != 2'h0 || i_req.addr[0]);
            end else begin
              s_next.pins.lower_store_n = 1'b0;
            end
          end
        end
      end
      EMBC_T1: begin
        s_next.pins.row_phase = 1'b0;
        if (s_reg.pins.row_phase) begin
          s_next.pins.addr = i_req.addr[21:0]; // Column phase
        end
        if (s_reg.lw_left != 3'h0) begin
          s_next.state = EMBC_LWAIT;
        end else if (s_reg.two_state) begin
          // Pin sampled on the edge that closes T1
          s_next.state = i_wait_n ? EMBC_TLAST : EMBC_PWAIT;
        end else begin
          s_next.state = EMBC_IDLE; // pin never looked at
          s_next.done = 1'b1;
        end
      end
      EMBC_LWAIT: begin
        // Pin sampled before the final long wait
        if (s_reg.lw_left == 3'h1) begin
          s_next.state = EMBC_IDLE;
          s_next.done = 1'b1;
        end else if (s_reg.lw_left == 3'h2 && s_reg.pin_wait && !i_wait_n)
        begin
          s_next.lw_left = s_reg.lw_left;
        end else begin
          s_next.lw_left = s_reg.lw_left - 3'h1;
        end
      end
      EMBC_PWAIT: begin
        if (i_wait_n) begin
          s_next.state = EMBC_TLAST;
        end
      end
      EMBC_TLAST: begin
        s_next.state = EMBC_IDLE;
        s_next.done = 1'b1;
      end
      default: s_next.state = EMBC_IDLE;
    endcase
    // Long-wait area with one long wait and pin waits: sample in T1
    if (s_reg.state == EMBC_T1 && s_reg.lw_left == 3'h1 &&
        s_reg.pin_wait && !i_wait_n) begin
      s_next.lw_left = 3'h2;
    end
    if (s_next.state == EMBC_IDLE && s_reg.state != EMBC_IDLE) begin
      s_next.pins.select_n = EMBC_SEL_IDLE;
      s_next.pins.fetch_n = 1'b1;
      s_next.pins.upper_store_n = 1'b1;
      s_next.pins.lower_store_n = 1'b1;
    end
    // Never hold the strobe past the end of a one-state cycle
    if (s_reg.state == EMBC_T1 && s_next.state != EMBC_IDLE &&
        !s_reg.pins.fetch_n && fetch_high) begin
      s_next.pins.fetch_n = 1'b0; // Duty phase kept in strobe generator
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      s_reg.state <= EMBC_IDLE;
      s_reg.lw_left <= EMBC_LW_RESET;
      s_reg.pin_wait <= 1'b0;
      s_reg.two_state <= 1'b0;
      s_reg.done <= 1'b0;
      s_reg.busy <= 1'b0;
      s_reg.dram <= 1'b0;
      s_reg.pins.select_n <= EMBC_SEL_IDLE;
      s_reg.pins.fetch_n <= 1'b1;
      s_reg.pins.upper_store_n <= 1'b1;
      s_reg.pins.lower_store_n <= 1'b1;
      s_reg.pins.a0_pin <= 1'b0;
      s_reg.pins.addr <= '0;
      s_reg.pins.row_phase <= 1'b0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign o_done = s_reg.done;
  assign o_busy = s_reg.busy;
  assign o_dram_access = s_reg.dram;
  assign o_select_n = s_reg.pins.select_n;
  assign o_fetch_n = s_reg.pins.fetch_n;
  assign o_upper_store_n = s_reg.pins.upper_store_n;
  assign o_lower_store_n = s_reg.pins.lower_store_n;
  assign o_a0_pin = s_reg.pins.a0_pin;
  assign o_addr = s_reg.pins.addr;
  assign o_row_phase = s_reg.pins.row_phase;
endmodule

// >>> test/embc_props.sv
// Checker for the bus cycle block: cycle length, selects, lanes, mux.
// Assumes it is bound to embc_top and sees only that module's ports.
module embc_props
  import embc_pkg::*;
(
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [2:0] i_boot_mode_pins,
  input wire embc_pkg::embc_cfg_t i_cfg,
  input wire embc_pkg::embc_req_t i_req,
  input wire logic i_wait_n,
  input wire logic o_done,
  input wire logic o_busy,
  input wire logic o_dram_access,
  input wire logic [7:0] o_select_n,
  input wire logic o_fetch_n,
  input wire logic o_upper_store_n,
  input wire logic o_lower_store_n,
  input wire logic o_a0_pin,
  input wire logic [21:0] o_addr,
  input wire logic o_row_phase
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  logic [2:0] ar;
  logic ext, pin, lng, a4w;
  logic [3:0] exp_c, cnt_reg, exp_reg;
  logic pin_reg;
  wire tk = i_req.valid && !o_busy && !o_done;
  wire dr = tk && ar == 3'h1 && i_cfg.dram_space_enable;
  always_comb begin
    ar = i_req.addr[26:24];
    case (ar)
      3'h0: ext = i_boot_mode_pins inside {EMBC_BOOT_EXT8, EMBC_BOOT_EXT16};
      3'h1: ext = !i_cfg.dram_space_enable;
      3'h5: ext = i_req.addr[27];
      3'h6: ext = !i_cfg.muxed_io_enable || i_req.addr[27];
      3'h7: ext = !i_req.addr[27];
      default: ext = 1'b1;
    endcase
    // Plain writes always wait on the pin; single-mode DMA uses second reg
    pin = i_req.dma_single ? i_cfg.wait_ctrl_second[ar]
        : (i_req.write || i_cfg.wait_ctrl_first[ar]);
    lng = ar inside {3'h0, 3'h2, 3'h6};
    if (ar == 3'h6) exp_c = 4'(i_cfg.long_wait_a6) + 4'h3;
    else if (lng) exp_c = 4'(i_cfg.long_wait_a02) + 4'h3;
    else exp_c = pin ? 4'h3 : 4'h2;
    a4w = ar == 3'h4 && i_req.addr[27] && i_req.write
        && !i_cfg.lane_strobe_select;
  end
  // Edges since take; wraps to zero and stops only past any wait count the bench uses
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) cnt_reg <= 4'h0;
    else if (tk && ext) cnt_reg <= 4'h1;
    else if (o_done) cnt_reg <= 4'h0;
    else if (cnt_reg != 4'h0) cnt_reg <= cnt_reg + 4'h1;
    if (tk) exp_reg <= exp_c;
    if (tk) pin_reg <= pin;
  end
  sequence s_take; tk && ext; endsequence
  // Ends on the edge that closes T1, where the wait pin is sampled
  sequence s_pin; tk && ext && pin && !lng ##1 1'b1; endsequence
  property p_len; o_done && cnt_reg != 0 && !pin_reg |-> cnt_reg == exp_reg;
  endproperty
  property p_len_pin;
    o_done && cnt_reg != 0 && pin_reg |-> cnt_reg >= exp_reg;
  endproperty
  property p_go; s_pin ##0 i_wait_n |=> ##1 o_done; endproperty
  property p_hold; s_pin ##0 !i_wait_n |=> ##1 !o_done; endproperty
  property p_rd_on; s_take ##0 !i_req.write |=> !o_fetch_n; endproperty
  property p_rd_off; o_done |-> o_fetch_n; endproperty
  property p_sel; s_take |=> o_select_n == ~(8'h01 << ar); endproperty
  property p_noext; tk && !ext |=> o_select_n == EMBC_SEL_IDLE; endproperty
  property p_idle; o_done |-> o_select_n == EMBC_SEL_IDLE; endproperty
  property p_dram; dr |=> o_dram_access; endproperty
  property p_row;
    dr && i_cfg.row_col_mux_enable && i_cfg.row_shift_select == EMBC_SHIFT8
    |=> o_row_phase && o_addr[15:0] == i_req.addr[23:8];
  endproperty
  property p_byte; tk && a4w && i_req.size == 2'h0 && i_req.addr[0]
    |=> o_upper_store_n && !o_lower_store_n; endproperty
  property p_word; tk && a4w && i_req.size != 2'h0
    |=> !o_upper_store_n && !o_lower_store_n; endproperty
  a_len: assert property (p_len) else $error("cycle length");
  a_len_pin: assert property (p_len_pin) else $error("short");
  a_go: assert property (p_go) else $error("no final state");
  a_hold: assert property (p_hold) else $error("wait skipped");
  a_sel: assert property (p_sel) else $error("select");
  a_noext: assert property (p_noext) else $error("stray select");
  a_idle: assert property (p_idle) else $error("select held");
  a_dram: assert property (p_dram) else $error("dram flag");
  a_row: assert property (p_row) else $error("row address");
  a_byte: assert property (p_byte) else $error("byte lane");
  a_word: assert property (p_word) else $error("word lanes");
  a_rd_on: assert property (p_rd_on) else $error("no read");
  a_rd_off: assert property (p_rd_off) else $error("read held");
endmodule

bind embc_top embc_props u_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
  .i_boot_mode_pins(i_boot_mode_pins), .i_cfg(i_cfg), .i_req(i_req),
  .i_wait_n(i_wait_n), .o_done(o_done), .o_busy(o_busy),
  .o_dram_access(o_dram_access), .o_select_n(o_select_n),
  .o_fetch_n(o_fetch_n), .o_upper_store_n(o_upper_store_n),
  .o_lower_store_n(o_lower_store_n), .o_a0_pin(o_a0_pin),
  .o_addr(o_addr), .o_row_phase(o_row_phase));

// >>> test/embc_mem_model.sv
// Far-side memory model: pulls the wait pin low for a window while selected.
// Assumes a pull-up on the wait line; bench sets delay and length.
module embc_mem_model (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_select_n,
  input wire logic [3:0] i_dly,
  input wire logic [3:0] i_len,
  output logic o_wait_n
);
  logic [3:0] cnt_reg;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || &i_select_n) cnt_reg <= 4'h0;
    else cnt_reg <= cnt_reg + 4'h1;
  end
  // Low from edge i_dly for i_len samples; pulled up when idle
  assign o_wait_n = &i_select_n || cnt_reg < i_dly
      || cnt_reg >= i_dly + i_len;
endmodule

// >>> test/tb.sv
// Bench for the bus cycle block: one task per scenario.
// Assumes the memory model on the wait pin and the bound checker.
`define CHK(a, e) begin num_checks++; if ((a) !== (e)) begin fails++; \
  $display("BAD %0t got %h exp %h", $time, a, e); end end
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import embc_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic wn, done, busy, dram, dr;
  logic [2:0] boot = 3'h1;
  logic [3:0] dly = 4'h0;
  logic [3:0] len = 4'h0;
  embc_cfg_t cfg;
  embc_req_t req;
  wire embc_pins_t p;
  embc_pins_t s1, s2;
  int fails = 0;
  int num_checks = 0;
  int n;
  always #5 clk = ~clk;
  embc_top dut (.i_ref_clk(clk), .i_rst(rst), .i_boot_mode_pins(boot),
    .i_cfg(cfg), .i_req(req), .i_wait_n(wn), .o_done(done), .o_busy(busy),
    .o_dram_access(dram), .o_select_n(p.select_n), .o_fetch_n(p.fetch_n),
    .o_upper_store_n(p.upper_store_n), .o_lower_store_n(p.lower_store_n),
    .o_a0_pin(p.a0_pin), .o_addr(p.addr), .o_row_phase(p.row_phase));
  embc_mem_model mem (.i_ref_clk(clk), .i_rst(rst), .i_select_n(p.select_n),
    .i_dly(dly), .i_len(len), .o_wait_n(wn));
  // Request held until done, then one idle cycle before the next
  task automatic run(input logic [27:0] a, input logic w,
    input logic [1:0] sz, input logic ds);
    req = '{1'b1, a, w, sz, ds};
    n = 0;
    do begin
      @(negedge clk);
      n++;
      if (n == 1) s1 = p;
      if (n == 1) dr = dram;
      if (n == 2) s2 = p;
    end while (done !== 1'b1 && n < 40);
    req.valid = 1'b0;
    @(negedge clk);
  endtask
  task automatic t_areas;
    logic [2:0] ar;
    logic x;
    logic [7:0] e;
    int c;
    cfg.muxed_io_enable = 1'b1;
    cfg.fetch_strobe_duty = 1'b1; // Bench clock is 100 MHz
    len = 4'h3;
    for (int i = 0; i < 16; i++) begin
      ar = 3'(i);
      x = ar == 3'h7 ? !i[3] : ar inside {3'h5, 3'h6} ? i[3] : 1'b1;
      e = x ? ~(8'h01 << ar) : 8'hff;
      run({i[3], ar, 24'h000010}, 1'b0, 2'h1, 1'b1);
      c = ar inside {3'h0, 3'h2, 3'h6} ? 3 : 2;
      `CHK(s1.select_n, e)
      `CHK(s1.fetch_n, 1'b0)
      if (x) `CHK(n, c)
    end
    boot = 3'h2;
    run(28'h0000010, 1'b0, 2'h1, 1'b1);
    `CHK(s1.select_n, 8'hff)
    boot = 3'h1;
    cfg.dram_space_enable = 1'b1;
    run(28'h1000010, 1'b0, 2'h1, 1'b1);
    `CHK(s1.select_n, 8'hff)
    `CHK(dr, 1'b1)
    cfg.dram_space_enable = 1'b0;
  endtask
  // Pin waits in areas 4, 2 and 6, never in area 3
  task automatic t_pin;
    dly = 4'h0;
    for (int k = 0; k < 3; k++) begin
      len = 4'(k);
      run(28'hc000100, 1'b0, 2'h1, 1'b0);
      `CHK(n, 3 + k)
      run(28'hc000100, 1'b1, 2'h1, 1'b0);
      `CHK(n, 3 + k)
    end
    cfg.wait_ctrl_second = 8'h10;
    run(28'hc000100, 1'b1, 2'h1, 1'b1);
    `CHK(n, 5)
    cfg.wait_ctrl_second = 8'h00;
    run(28'hc000100, 1'b1, 2'h1, 1'b1);
    `CHK(n, 2)
    cfg.long_wait_a02 = 2'h1;
    cfg.long_wait_a6 = 2'h2;
    dly = 4'h1;
    run(28'h2000100, 1'b0, 2'h1, 1'b0);
    `CHK(n, 6)
    dly = 4'h2;
    run(28'he000100, 1'b1, 2'h1, 1'b0);
    `CHK(n, 7)
  endtask
  task automatic t_lane;
    logic [2:0] e [6] = '{3'h6, 3'h1, 3'h0, 3'h4, 3'h2, 3'h0};
    logic [2:0] v;
    len = 4'h0;
    for (int i = 0; i < 6; i++) begin
      cfg.lane_strobe_select = i > 2;
      run({27'h6000008, 1'(i % 3 == 0)}, 1'b1, 2'(i % 3 == 2), 1'b0);
      v = {s1.a0_pin, s1.upper_store_n, s1.lower_store_n};
      `CHK(v, e[i])
    end
    // 8-bit space keeps A0 and the lower store strobe, lane select on
    run(28'h4000011, 1'b1, 2'h0, 1'b0);
    v = {s1.a0_pin, s1.upper_store_n, s1.lower_store_n};
    `CHK(v, 3'h6)
    cfg.lane_strobe_select = 1'b0;
  endtask
  task automatic t_mux;
    logic [15:0] m;
    logic [15:0] r;
    cfg.dram_space_enable = 1'b1;
    cfg.row_col_mux_enable = 1'b1;
    // Code 11 is reserved and never driven
    for (int sh = 0; sh < 3; sh++) begin
      cfg.row_shift_select = 2'(sh);
      m = 16'hffff >> sh;
      r = 16'(24'ha5c3e7 >> (8 + sh));
      run(28'h9a5c3e7, 1'b0, 2'h1, 1'b0);
      `CHK(s1.row_phase, 1'b1)
      `CHK(s1.addr[15:0] & m, r)
      `CHK(s2.addr, 22'h25c3e7)
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  // Whole run is well under a thousand cycles
  initial begin
    #50us;
    fails++;
    print_verdict;
  end
  initial begin
    cfg = '0;
    cfg.wait_ctrl_first = 8'hff;
    req = '0;
    repeat (2) @(negedge clk);
    rst = 1'b0;
    t_areas;
    t_pin;
    t_lane;
    t_mux;
    print_verdict;
  end
endmodule
